/* File: hw/ulms_map.svh */
// Purpose: Offsets, field positions and reset values of the status block
// Assumes: 3-bit register address, 8-bit data
// Notes:   Included by the status core and the testbench
`ifndef ULMS_MAP_SVH
`define ULMS_MAP_SVH
`define ULMS_LINE_STATUS_ADDR     3'h5
`define ULMS_MODEM_STATUS_ADDR    3'h6
`define ULMS_EXTRA_FEATURE_ADDR   3'h7
`define ULMS_XFR_RESET            8'h00
`define ULMS_XFR_HALF_DUPLEX      0
`define ULMS_XFR_IR_INVERT        1
`define ULMS_XFR_AUTO_485         2
`define ULMS_XFR_ERR_EARLY        3
`define ULMS_XFR_XON_ANY          4
`define ULMS_XFR_485_INVERT       5
`define ULMS_XFR_USED_MASK        8'h3F
`define ULMS_MCR_DTR              0
`define ULMS_MCR_RTS              1
`define ULMS_MCR_OUT1             2
`define ULMS_MCR_OUT2             3
`define ULMS_MCR_LOOP             4
`define ULMS_MCR_IR_EN            6
`define ULMS_MCR_PRESCALE         7
`define ULMS_PRESCALE_LAST        2'h3
`define ULMS_ERRCNT_ONE           6'h01
`endif

/* File: hw/ulms_pkg.sv */
// Purpose: Types shared by the line and modem status block
// Assumes: Pin levels are the raw active-low modem pins
// Notes:   Offsets live in ulms_map.svh
package ulms_pkg;
   typedef struct packed {
      logic done;
      logic perr;
      logic ferr;
      logic brk;
   } ulms_rx_evt_s;

   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic ri_n;
      logic cd_n;
   } ulms_pins_s;

   typedef struct packed {
      logic [1:0] pre_cnt;
      logic       tick;
      logic       ovr;
      logic       brk;
      logic       pend;
      logic [5:0] errcnt;
      logic       brk_run;
      logic       head_err;
      logic [7:0] extra_feature_control;
      logic [3:0] mst;
      logic [3:0] delta;
      logic [7:0] rdata;
      logic       lsr_irq;
      logic       msr_irq;
      logic       rts_n;
      logic       rx_line;
      logic       halt;
      logic       push;
      logic       xon;
   } ulms_state_s;
endpackage : ulms_pkg

/* File: hw/ulms_core.sv */
// Purpose: Line status, modem status and extra feature control of a UART
// Assumes: All inputs synchronous to clock_i; FIFOs and shifters live outside
// Notes:   Register reads answer one cycle after the read strobe
// Behaviour
// R1: Prescale bit 0 passes clock to baud generator; 1 divides by four.
// R2: Data-ready reads 1 while any received character is held.
// R3: Char arriving on full FIFO sets overrun, is dropped, interrupts at once.
// R4: Parity flag follows the character at the read position.
// R5: Framing flag follows the character at the read position.
// R6: Line low a whole frame flags break; only one break char enters FIFO.
// R7: Line status read clears break even if the line stays low.
// R8: Early-error bit picks error interrupt on receipt or at read position; when set, code also interrupts as an error reaches the read position.
// R9: Holding-empty flag equals transmit FIFO empty.
// R10: Transmitter-empty needs both FIFO and shift register empty.
// R11: FIFO error summary set while any stored char has an error.
// R12: Infrared half-duplex mutes the receiver while transmitting.
// R13: Infrared polarity bit picks idle-low or idle-high input.
// R14: Auto RS-485 drives the request-to-send pin as direction control.
// R15: RS-485 direction high when sending unless the invert bit is set.
// R16: Xon-any restarts transmission on any received character.
// R17: Four delta bits set on modem input change; enable gates interrupt.
// R18: Ring delta only when ring pin goes low to high.
// R19: Auto clear-to-send halts transmitter while the pin is high.
// R20: Clear-to-send state is inverted pin, or request bit in loopback.
// R21: Loopback maps ring, carrier, data-set-ready to control bits.
// R22: Extra feature bits writable only with enhanced enable set.
// R23: Modem status read clears the four delta bits.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "ulms_map.svh"

module ulms_core
   import ulms_pkg::*;
(
   input  wire logic         clock_i,         // 20 MHz clock
   input  wire logic         reset_i,         // Sync reset, high
   input  wire logic [2:0]   addr_i,          // Register address
   input  wire logic [7:0]   wdata_i,         // Write data
   input  wire logic         wr_i,            // Write strobe
   input  wire logic         rd_i,            // Read strobe
   output logic      [7:0]   rdata_o,         // Read data, next cycle
   input  wire logic [7:0]   modem_control_i, // Modem control register
   input  wire logic         enh_enable_i,    // Enhanced function enable
   input  wire logic         ier_line_i,      // Line status irq enable
   input  wire logic         ier_modem_i,     // Modem status irq enable
   input  wire logic         sw_flow_i,       // Software flow control on
   input  wire logic         auto_cts_i,      // Auto CTS enable
   input  wire ulms_rx_evt_s rx_evt_i,        // Character complete
   input  wire logic         rx_full_i,       // Receive FIFO full
   input  wire logic         rx_empty_i,      // Receive FIFO empty
   input  wire ulms_rx_evt_s rx_head_i,       // Flags of head char
   input  wire logic         rx_pop_i,        // Host reads head char
   input  wire logic         tx_empty_i,      // Transmit FIFO empty
   input  wire logic         tx_shift_empty_i,// Transmit shifter empty
   input  wire logic         tx_busy_i,       // Transmitting
   input  wire ulms_pins_s   pins_i,          // Modem pins, active low
   input  wire logic         serial_rx_i,     // Normal serial input
   input  wire logic         irda_rx_i,       // Infrared input
   output logic              baud_tick_o,     // Baud generator enable
   output logic              rx_push_o,       // Write char to FIFO
   output logic              rx_line_o,       // Conditioned receive line
   output logic              rts_n_o,         // Request-to-send pin
   output logic              tx_halt_o,       // Hold transmitter
   output logic              xon_resume_o,    // Resume transmission
   output logic              lsr_irq_o,       // Line status interrupt
   output logic              msr_irq_o        // Modem status interrupt
);

   ulms_state_s s_q;
   ulms_state_s s_d;

   function automatic logic has_err(input ulms_rx_evt_s e);
      has_err = e.perr | e.ferr | e.brk;
   endfunction : has_err

   logic       lsr_rd;
   logic       msr_rd;
   logic       loop;
   logic [3:0] mnow;
   logic [7:0] lsr_val;
   logic       drop;
   logic       accept;
   logic       head_err;
   logic       ir_in;

   always_comb begin
      lsr_rd = rd_i && (addr_i == `ULMS_LINE_STATUS_ADDR);
      msr_rd = rd_i && (addr_i == `ULMS_MODEM_STATUS_ADDR);
      loop   = modem_control_i[`ULMS_MCR_LOOP];
      // State order: cts, dsr, ri, cd
      if (loop) begin
         mnow = {modem_control_i[`ULMS_MCR_RTS],    // R20
                 modem_control_i[`ULMS_MCR_DTR],    // R21
                 modem_control_i[`ULMS_MCR_OUT1],   // R21
                 modem_control_i[`ULMS_MCR_OUT2]};  // R21
      end else begin
         mnow = ~{pins_i.cts_n, pins_i.dsr_n, pins_i.ri_n, pins_i.cd_n}; // R20
      end
      drop     = rx_evt_i.done && rx_full_i;                 // R3
      // A break held over several frames yields one FIFO entry only
      accept   = rx_evt_i.done && !rx_full_i
                 && !(rx_evt_i.brk && s_q.brk_run);          // R6
      head_err = !rx_empty_i && has_err(rx_head_i);
      lsr_val  = {(s_q.errcnt != 6'h00),                     // R11
                  tx_empty_i && tx_shift_empty_i,            // R10
                  tx_empty_i,                                // R9
                  s_q.brk,                                   // R6
                  head_err && rx_head_i.ferr,                // R5
                  head_err && rx_head_i.perr,                // R4
                  s_q.ovr,
                  !rx_empty_i};                              // R2
      // Decoded line idles high like a wired serial input, whatever the sense
      ir_in    = ~(irda_rx_i ^ s_q.extra_feature_control[`ULMS_XFR_IR_INVERT]); // R13
   end

   always_comb begin
      s_d = s_q;

      // Prescaler
      if (modem_control_i[`ULMS_MCR_PRESCALE]) begin
         s_d.pre_cnt = s_q.pre_cnt + 2'h1;
         s_d.tick    = (s_q.pre_cnt == `ULMS_PRESCALE_LAST); // R1
      end else begin
         s_d.pre_cnt = 2'h0;
         s_d.tick    = 1'b1;                                 // R1
      end

      // Sticky overrun and break; a set in the clearing cycle wins
      if (lsr_rd) begin
         s_d.ovr  = 1'b0;
         s_d.brk  = 1'b0;                                    // R7
         s_d.pend = 1'b0;                                    // R8
      end
      if (drop) begin
         s_d.ovr = 1'b1;                                     // R3
      end
      if (accept && rx_evt_i.brk) begin
         s_d.brk = 1'b1;                                     // R6
      end

      // Break run ends once the line is seen idle again
      if (rx_evt_i.done) begin
         s_d.brk_run = rx_evt_i.brk;
      end else if (s_q.rx_line) begin
         s_d.brk_run = 1'b0;
      end

      // Count of stored characters carrying an error
      case ({accept && has_err(rx_evt_i), rx_pop_i && head_err})
         2'b10:   s_d.errcnt = s_q.errcnt + `ULMS_ERRCNT_ONE;  // R11
         2'b01:   s_d.errcnt = s_q.errcnt - `ULMS_ERRCNT_ONE;  // R11
         default: s_d.errcnt = s_q.errcnt;
      endcase

      // Error interrupt timing
      s_d.head_err = head_err;
      if (s_q.extra_feature_control[`ULMS_XFR_ERR_EARLY] && rx_evt_i.done
          && has_err(rx_evt_i)) begin
         s_d.pend = 1'b1;                                    // R8
      end
      if (head_err && !s_q.head_err) begin
         s_d.pend = 1'b1;                                    // R8
      end
      // In compatible mode the error at the read position holds the request
      s_d.lsr_irq = ier_line_i && (s_d.ovr || s_d.pend ||
                    (!s_q.extra_feature_control[`ULMS_XFR_ERR_EARLY] && head_err)); // R3 R8

      // Extra feature register, frozen when enhanced functions are off
      if (wr_i && (addr_i == `ULMS_EXTRA_FEATURE_ADDR) && enh_enable_i) begin
         s_d.extra_feature_control = wdata_i & `ULMS_XFR_USED_MASK;            // R22
      end

      // Modem status deltas
      s_d.mst = mnow;
      if (msr_rd) begin
         s_d.delta = 4'h0;                                   // R23
      end
      s_d.delta[3] = s_d.delta[3] | (mnow[3] ^ s_q.mst[3]);  // R17
      s_d.delta[2] = s_d.delta[2] | (mnow[2] ^ s_q.mst[2]);  // R17
      s_d.delta[1] = s_d.delta[1] | (s_q.mst[1] & ~mnow[1]); // R18
      s_d.delta[0] = s_d.delta[0] | (mnow[0] ^ s_q.mst[0]);  // R17
      s_d.msr_irq  = ier_modem_i && (s_d.delta != 4'h0);     // R17

      // Read data
      if (lsr_rd) begin
         s_d.rdata = lsr_val;
      end else if (msr_rd) begin
         s_d.rdata = {s_q.mst[0], s_q.mst[1], s_q.mst[2], s_q.mst[3],
                      s_q.delta[0], s_q.delta[1], s_q.delta[2], s_q.delta[3]};
      end else begin
         // Write-only extra feature register and unmapped addresses read 0
         s_d.rdata = 8'h00;
      end

      // Direction control takes over the request-to-send pin
      if (s_q.extra_feature_control[`ULMS_XFR_AUTO_485]) begin
         s_d.rts_n = tx_busy_i ^ s_q.extra_feature_control[`ULMS_XFR_485_INVERT]; // R14 R15
      end else begin
         s_d.rts_n = ~modem_control_i[`ULMS_MCR_RTS];
      end

      // Receive line conditioning
      if (modem_control_i[`ULMS_MCR_IR_EN]) begin
         if (s_q.extra_feature_control[`ULMS_XFR_HALF_DUPLEX] && tx_busy_i) begin
            // A muted receiver must see mark, else it would report a break
            s_d.rx_line = 1'b1;                              // R12
         end else begin
            s_d.rx_line = ir_in;                             // R13
         end
      end else begin
         s_d.rx_line = serial_rx_i;
      end

      // Transmitter finishes its current character before obeying this
      s_d.halt = auto_cts_i && pins_i.cts_n;                 // R19
      s_d.push = accept;                                     // R3 R6
      s_d.xon  = sw_flow_i && s_q.extra_feature_control[`ULMS_XFR_XON_ANY]
                 && rx_evt_i.done;                           // R16
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         s_q         <= '0;
         s_q.extra_feature_control     <= `ULMS_XFR_RESET;
         s_q.rts_n   <= 1'b1;
         s_q.rx_line <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o      = s_q.rdata;
   assign baud_tick_o  = s_q.tick;
   assign rx_push_o    = s_q.push;
   assign rx_line_o    = s_q.rx_line;
   assign rts_n_o      = s_q.rts_n;
   assign tx_halt_o    = s_q.halt;
   assign xon_resume_o = s_q.xon;
   assign lsr_irq_o    = s_q.lsr_irq;
   assign msr_irq_o    = s_q.msr_irq;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   chk_prescale_quarter: assert property ( // R1
      modem_control_i[`ULMS_MCR_PRESCALE] && baud_tick_o ##1
      modem_control_i[`ULMS_MCR_PRESCALE] |-> !baud_tick_o)
      else $error("prescaler ticked twice in a row");

   chk_prescale_pass: assert property ( // R1
      !modem_control_i[`ULMS_MCR_PRESCALE] |=> baud_tick_o)
      else $error("undivided clock missed a tick");

   chk_ready_read: assert property ( // R2
      lsr_rd |=> rdata_o[0] == $past(!rx_empty_i))
      else $error("data ready bit wrong");

   chk_overrun_drop: assert property ( // R3
      drop |=> !rx_push_o ##0 (lsr_irq_o || !$past(ier_line_i)))
      else $error("overrun char pushed or irq late");

   chk_break_clear: assert property ( // R7
      lsr_rd && !accept ##1 rd_i && addr_i == `ULMS_LINE_STATUS_ADDR
      |=> !rdata_o[4])
      else $error("break not cleared by status read");

   chk_tx_empty: assert property ( // R10
      lsr_rd && !tx_shift_empty_i |=> !rdata_o[6])
      else $error("transmitter empty while shifting");

   chk_xfr_frozen: assert property ( // R22
      !enh_enable_i |=> $stable(s_q.extra_feature_control))
      else $error("extra feature bits changed while locked");

   chk_rs485_dir: assert property ( // R15
      s_q.extra_feature_control[`ULMS_XFR_AUTO_485] && $stable(s_q.extra_feature_control)
      |=> rts_n_o == ($past(tx_busy_i) ^ $past(s_q.extra_feature_control[`ULMS_XFR_485_INVERT])))
      else $error("direction output wrong polarity");

   chk_ring_delta: assert property ( // R18
      !msr_rd && s_q.mst[1] == 1'b0 && mnow[1] ##1 !msr_rd && mnow[1]
      |=> !s_q.delta[1] || $past(s_q.delta[1], 2))
      else $error("ring delta set on wrong edge");

   chk_cts_halt: assert property ( // R19
      auto_cts_i && pins_i.cts_n |=> tx_halt_o)
      else $error("transmitter not halted");

   chk_delta_clear: assert property ( // R23
      msr_rd && mnow == s_q.mst |=> s_q.delta == 4'h0)
      else $error("delta bits survived status read");

   chk_parity_head: assert property ( // R4
      lsr_rd |=> rdata_o[2] == $past(!rx_empty_i && rx_head_i.perr))
      else $error("parity flag does not follow head char");

   chk_framing_head: assert property ( // R5
      lsr_rd |=> rdata_o[3] == $past(!rx_empty_i && rx_head_i.ferr))
      else $error("framing flag does not follow head char");

   chk_break_once: assert property ( // R6
      rx_evt_i.done && rx_evt_i.brk && s_q.brk_run |=> !rx_push_o)
      else $error("second break char pushed");

   chk_break_sets: assert property ( // R6
      rx_evt_i.done && rx_evt_i.brk && !rx_full_i && !s_q.brk_run
      |=> rx_push_o && s_q.brk)
      else $error("first break char not flagged");

   chk_hold_empty: assert property ( // R9
      lsr_rd |=> rdata_o[5] == $past(tx_empty_i))
      else $error("holding empty flag wrong");

   chk_err_summary: assert property ( // R11
      accept && has_err(rx_evt_i) |=> s_q.errcnt != 6'h00)
      else $error("stored error not counted");

   chk_early_irq: assert property ( // R8
      ier_line_i && s_q.extra_feature_control[`ULMS_XFR_ERR_EARLY] && rx_evt_i.done
      && has_err(rx_evt_i) |=> lsr_irq_o)
      else $error("early error interrupt missing");

   chk_compat_irq: assert property ( // R8
      ier_line_i && !s_q.extra_feature_control[`ULMS_XFR_ERR_EARLY] && head_err |=> lsr_irq_o)
      else $error("error interrupt at read position missing");

   chk_ir_mute: assert property ( // R12
      modem_control_i[`ULMS_MCR_IR_EN] && s_q.extra_feature_control[`ULMS_XFR_HALF_DUPLEX] && tx_busy_i
      |=> rx_line_o)
      else $error("receiver not muted while sending");

   chk_ir_sense: assert property ( // R13
      modem_control_i[`ULMS_MCR_IR_EN]
      && !(s_q.extra_feature_control[`ULMS_XFR_HALF_DUPLEX] && tx_busy_i)
      |=> rx_line_o == $past(~(irda_rx_i ^ s_q.extra_feature_control[`ULMS_XFR_IR_INVERT])))
      else $error("infrared input sense wrong");

   chk_rts_manual: assert property ( // R14
      !s_q.extra_feature_control[`ULMS_XFR_AUTO_485] |=> rts_n_o == $past(!modem_control_i[`ULMS_MCR_RTS]))
      else $error("request pin ignores control bit");

   chk_xon_any: assert property ( // R16
      sw_flow_i && s_q.extra_feature_control[`ULMS_XFR_XON_ANY] && rx_evt_i.done |=> xon_resume_o)
      else $error("any char did not resume");

   chk_cts_delta: assert property ( // R17
      mnow[3] != s_q.mst[3] |=> s_q.delta[3])
      else $error("clear-to-send change not flagged");

   chk_modem_irq: assert property ( // R17
      ier_modem_i && s_q.delta != 4'h0 && !msr_rd |=> msr_irq_o)
      else $error("modem interrupt missing");

   chk_cts_loop: assert property ( // R20
      loop |=> s_q.mst[3] == $past(modem_control_i[`ULMS_MCR_RTS]))
      else $error("loopback clear-to-send wrong");

   chk_dsr_loop: assert property ( // R21
      loop |=> s_q.mst[2:0] == $past({modem_control_i[`ULMS_MCR_DTR],
                                      modem_control_i[`ULMS_MCR_OUT1],
                                      modem_control_i[`ULMS_MCR_OUT2]}))
      else $error("loopback modem states wrong");

endmodule : ulms_core

/* File: bench/ulms_modem_line.sv */
// Purpose: Far-end modem and serial line model for the status block
// Assumes: The bench asks for line levels; they reach the pins one clock later
// Notes:   Pins are raw active-low levels, idling inactive (high)
`timescale 1ns/100ps
module ulms_modem_line
   import ulms_pkg::*;
(
   input  wire logic       clock_i, // Device clock
   input  wire ulms_pins_s want_i,  // Requested modem pin levels
   input  wire logic       rx_i,    // Requested serial line level
   input  wire logic       ir_i,    // Requested infrared detector level
   output ulms_pins_s      pins_o = '1,   // Modem pins to the device
   output logic            rx_o   = 1'h1, // Serial line to the device
   output logic            ir_o   = 1'h0  // Infrared detector output
);
   // A real modem answers through cables and drivers, never in the same edge
   always @(posedge clock_i) begin
      pins_o <= want_i;
      rx_o   <= rx_i;
      ir_o   <= ir_i;
   end
endmodule : ulms_modem_line

/* File: bench/testbench.sv */
// Purpose: Self-checking bench for the line and modem status block
// Assumes: Level outputs settle within three clocks of their cause
// Notes:   FIFO and shifter levels are plain bench-driven levels
`timescale 1ns/100ps
`include "ulms_map.svh"
module testbench
   import ulms_pkg::*;
;
   localparam logic [2:0] ls_a = `ULMS_LINE_STATUS_ADDR;
   localparam logic [2:0] ms_a = `ULMS_MODEM_STATUS_ADDR;
   localparam logic [2:0] xf_a = `ULMS_EXTRA_FEATURE_ADDR;
   logic         clock_i = 1'h0, reset_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
   logic [2:0]   addr_i = 3'h0;
   logic [7:0]   wdata_i = 8'h00, modem_control_i = 8'h00, rdata_o, got;
   logic         enh_enable_i = 1'h0, ier_line_i = 1'h0, ier_modem_i = 1'h0;
   logic         sw_flow_i = 1'h0, auto_cts_i = 1'h0, rx_full_i = 1'h0, rx_empty_i = 1'h1;
   logic         rx_pop_i = 1'h0, tx_empty_i = 1'h1, tx_shift_empty_i = 1'h1, tx_busy_i = 1'h0;
   logic         want_rx = 1'h1, want_ir = 1'h0, serial_rx_i, irda_rx_i;
   ulms_rx_evt_s rx_evt_i = '0, rx_head_i = '0;
   ulms_pins_s   want = '1, pins_i;
   logic         baud_tick_o, rx_push_o, rx_line_o, rts_n_o, tx_halt_o;
   logic         xon_resume_o, lsr_irq_o, msr_irq_o;
   int           n_mismatch = 0, num_checks = 0, n_tick = 0, n_push = 0, n_xon = 0, t0;

   always #25 clock_i = ~clock_i;

   ulms_core ulms_core_inst (.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .modem_control_i, .enh_enable_i, .ier_line_i, .ier_modem_i, .sw_flow_i, .auto_cts_i,
      .rx_evt_i, .rx_full_i, .rx_empty_i, .rx_head_i, .rx_pop_i, .tx_empty_i,
      .tx_shift_empty_i, .tx_busy_i, .pins_i, .serial_rx_i, .irda_rx_i, .baud_tick_o,
      .rx_push_o, .rx_line_o, .rts_n_o, .tx_halt_o, .xon_resume_o, .lsr_irq_o, .msr_irq_o);
   ulms_modem_line ulms_modem_line_inst (.clock_i, .want_i(want), .rx_i(want_rx),
      .ir_i(want_ir), .pins_o(pins_i), .rx_o(serial_rx_i), .ir_o(irda_rx_i));

   // Pulse outputs are counted so no single cycle can be missed
   always @(posedge clock_i) begin
      if (baud_tick_o === 1'h1) n_tick <= n_tick + 1;
      if (rx_push_o === 1'h1) n_push <= n_push + 1;
      if (xon_resume_o === 1'h1) n_xon <= n_xon + 1;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask : cyc
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'h1;
      @(posedge clock_i);
      wr_i    <= 1'h0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'h1;
      @(posedge clock_i);
      rd_i   <= 1'h0;
      @(posedge clock_i);
      got = rdata_o;
   endtask : rd_reg
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, wanted %h", $time, g, e);
      end
   endtask : cmp_byte
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      rd_reg(a);
      cmp_byte(got, e);
   endtask : rd_chk
   task automatic pulse(input ulms_rx_evt_s e);
      @(posedge clock_i);
      rx_evt_i <= e;
      @(posedge clock_i);
      rx_evt_i <= '0;
      cyc(2);
   endtask : pulse
   task automatic pop(input ulms_rx_evt_s h);
      @(posedge clock_i);
      rx_head_i <= h;
      rx_pop_i  <= 1'h1;
      @(posedge clock_i);
      rx_pop_i  <= 1'h0;
      rx_head_i <= '0;
      cyc(2);
   endtask : pop
   task automatic close_out;
      $display("mismatches %0d, checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (3000) @(posedge clock_i);
      n_mismatch++;
      close_out();
   end

   initial begin
      cyc(5);
      reset_i <= 1'h0;
      rd_chk(ls_a, 8'h60);
      rd_reg(ms_a);
      tx_shift_empty_i <= 1'h0;
      rd_chk(ls_a, 8'h20);
      tx_empty_i <= 1'h0;
      rd_chk(ls_a, 8'h00);
      rx_empty_i <= 1'h0;
      tx_empty_i <= 1'h1;
      tx_shift_empty_i <= 1'h1;
      rd_chk(ls_a, 8'h61);
      rd_chk(3'h0, 8'h00);
      // Overrun: a full FIFO drops the character
      ier_line_i <= 1'h1;
      rx_full_i <= 1'h1;
      pulse(4'h8);
      cmp_byte(8'(n_push), 8'h00);
      cmp_byte({7'h0, lsr_irq_o}, 8'h01);
      rd_chk(ls_a, 8'h63);
      rd_chk(ls_a, 8'h61);
      rx_full_i <= 1'h0;
      sw_flow_i <= 1'h1;
      pulse(4'h8);
      cmp_byte(8'(n_xon), 8'h00);
      enh_enable_i <= 1'h1;
      wr_reg(xf_a, 8'h18);
      pulse(4'hC);
      cmp_byte(8'(n_push), 8'h02);
      cmp_byte(8'(n_xon), 8'h01);
      cmp_byte({7'h0, lsr_irq_o}, 8'h01);
      rd_chk(ls_a, 8'hE1);
      cyc(2);
      cmp_byte({7'h0, lsr_irq_o}, 8'h00);
      rx_head_i <= 4'h4;
      cyc(3);
      cmp_byte({7'h0, lsr_irq_o}, 8'h01);
      rd_chk(ls_a, 8'hE5);
      wr_reg(xf_a, 8'h00);
      rx_head_i <= 4'h2;
      cyc(3);
      cmp_byte({7'h0, lsr_irq_o}, 8'h01);
      rd_chk(ls_a, 8'hE9);
      pop(4'h4);
      rd_chk(ls_a, 8'h61);
      // Early-error off: a bad arrival alone must not interrupt
      pulse(4'hA);
      cmp_byte({7'h0, lsr_irq_o}, 8'h00);
      pop(4'h2);
      // Break held over two frames loads one character only
      want_rx <= 1'h0;
      pulse(4'h9);
      pulse(4'h9);
      cmp_byte(8'(n_push), 8'h04);
      rd_reg(ls_a);
      cmp_byte(got & 8'h10, 8'h10);
      rd_reg(ls_a);
      cmp_byte(got & 8'h10, 8'h00);
      want_rx <= 1'h1;
      ier_modem_i <= 1'h1;
      want.cts_n <= 1'h0;
      cyc(3);
      cmp_byte({7'h0, msr_irq_o}, 8'h01);
      rd_chk(ms_a, 8'h11);
      rd_chk(ms_a, 8'h10);
      want.ri_n <= 1'h0;
      cyc(3);
      rd_chk(ms_a, 8'h50);
      want.ri_n <= 1'h1;
      cyc(3);
      rd_chk(ms_a, 8'h14);
      want.dsr_n <= 1'h0;
      want.cd_n <= 1'h0;
      cyc(3);
      rd_chk(ms_a, 8'hBA);
      auto_cts_i <= 1'h1;
      want.cts_n <= 1'h1;
      cyc(4);
      cmp_byte({7'h0, tx_halt_o}, 8'h01);
      want.cts_n <= 1'h0;
      cyc(4);
      cmp_byte({7'h0, tx_halt_o}, 8'h00);
      modem_control_i <= 8'h1F;
      cyc(3);
      rd_reg(ms_a);
      cmp_byte(got & 8'hF0, 8'hF0);
      modem_control_i <= 8'h10;
      cyc(3);
      rd_reg(ms_a);
      cmp_byte(got & 8'hF0, 8'h00);
      // Direction control, with locked and unlocked feature writes
      modem_control_i <= 8'h02;
      tx_busy_i <= 1'h1;
      enh_enable_i <= 1'h0;
      wr_reg(xf_a, 8'h04);
      cyc(3);
      cmp_byte({7'h0, rts_n_o}, 8'h00);
      enh_enable_i <= 1'h1;
      wr_reg(xf_a, 8'h04);
      cyc(3);
      cmp_byte({7'h0, rts_n_o}, 8'h01);
      tx_busy_i <= 1'h0;
      cyc(3);
      cmp_byte({7'h0, rts_n_o}, 8'h00);
      wr_reg(xf_a, 8'h24);
      enh_enable_i <= 1'h0;
      wr_reg(xf_a, 8'h00);
      cyc(3);
      cmp_byte({7'h0, rts_n_o}, 8'h01);
      // Infrared polarity and half-duplex muting
      enh_enable_i <= 1'h1;
      modem_control_i <= 8'h40;
      want_ir <= 1'h1;
      cyc(3);
      cmp_byte({7'h0, rx_line_o}, 8'h00);
      wr_reg(xf_a, 8'h02);
      cyc(3);
      cmp_byte({7'h0, rx_line_o}, 8'h01);
      want_ir <= 1'h0;
      tx_busy_i <= 1'h1;
      cyc(3);
      cmp_byte({7'h0, rx_line_o}, 8'h00);
      wr_reg(xf_a, 8'h03);
      cyc(3);
      cmp_byte({7'h0, rx_line_o}, 8'h01);
      modem_control_i <= 8'h00;
      cyc(4);
      t0 = n_tick;
      cyc(16);
      cmp_byte(8'(n_tick - t0), 8'h10);
      modem_control_i <= 8'h80;
      cyc(4);
      t0 = n_tick;
      cyc(16);
      cmp_byte(8'(n_tick - t0), 8'h04);
      close_out();
   end
endmodule : testbench
